//--- hw/byte_abs_diff_unit.sv
`timescale 1ns/1ps
module byte_abs_diff_unit
  import sad_mul_pkg::*;
(
  input wire logic [DATA_W-1:0] first_operand, // Minuend bytes
  input wire logic [DATA_W-1:0] second_operand, // Subtrahend bytes
  output logic [DATA_W-1:0] total, // Sum of |a-b|, zero extended
  output logic [DATA_W-1:0] byte_lanes, // Per-byte wrapped differences
  output logic [DATA_W-1:0] half_lanes // Per-halfword wrapped differences
);

  logic [LANE8_N-1:0][9:0] abs_ext;

  genvar g;
  generate
    for (g = 0; g < LANE8_N; g++) begin : g_byte
      logic [7:0] a;
      logic [7:0] b;
      assign a = first_operand[8*g +: 8];
      assign b = second_operand[8*g +: 8];
      assign abs_ext[g] = (a >= b) ? {2'h0, a - b} : {2'h0, b - a};
      assign byte_lanes[8*g +: 8] = a - b;
    end
    for (g = 0; g < LANE16_N; g++) begin : g_half
      assign half_lanes[16*g +: 16] =
        first_operand[16*g +: 16] - second_operand[16*g +: 16];
    end
  endgenerate

  // Four 8-bit magnitudes fit in ten bits, so no carry is lost
  assign total = {22'h0, abs_ext[0] + abs_ext[1] + abs_ext[2] + abs_ext[3]};

endmodule : byte_abs_diff_unit

//--- hw/sad_mul_pkg.sv
package sad_mul_pkg;

  localparam int DATA_W = 32;
  localparam int WIDE_W = 64;
  localparam int REG_IDX_W = 4;
  localparam int OP_W = 4;
  localparam int LANE8_N = 4;
  localparam int LANE16_N = 2;
  localparam int FLAG_N_BIT = 3;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_C_BIT = 1;
  localparam int FLAG_V_BIT = 0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [REG_IDX_W-1:0] STACK_POINTER_REG = 4'hD;
  localparam logic [REG_IDX_W-1:0] PROGRAM_COUNTER_REG = 4'hF;
  localparam logic [REG_IDX_W-1:0] LOW_REG_LIMIT = 4'h7;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [OP_W-1:0] {
    OP_BYTE_ABS_DIFF_TOTAL = 4'h0,
    OP_BYTE_ABS_DIFF_TOTAL_ACC = 4'h1,
    OP_HALFWORD_LANE_DIFFERENCE = 4'h2,
    OP_BYTE_LANE_DIFFERENCE = 4'h3,
    OP_PRODUCT_LOW_WORD = 4'h4,
    OP_PRODUCT_PLUS_ADDEND = 4'h5,
    OP_ADDEND_MINUS_PRODUCT = 4'h6,
    OP_UNSIGNED_WIDE_PRODUCT = 4'h7,
    OP_UNSIGNED_WIDE_PRODUCT_ACC = 4'h8,
    OP_UNSIGNED_WIDE_PRODUCT_TWO_ADDENDS = 4'h9,
    OP_SIGNED_WIDE_PRODUCT = 4'hA,
    OP_SIGNED_WIDE_PRODUCT_ACC = 4'hB
  } op_t;

endpackage : sad_mul_pkg

//--- hw/sad_subtract_multiply_datapath.sv
// Summary of operation
// - Byte absolute differences summed into destination
// - Accumulating form adds addend register
// - Halfword lanes subtract independently, unsigned
// - Byte lanes subtract independently, unsigned
// - Difference and subtract ops leave flags
// - Multiply keeps low 32 product bits
// - Multiply-subtract takes product from addend
// - Low word independent of operand signedness
// - Flag option updates flags on plain multiply only
// - Omitted destination writes first operand register, except on long forms
// - Unsigned long multiplies give 64-bit results
// - Signed long multiplies give 64-bit results
// - Flag multiply sets N,Z; keeps C,V
`timescale 1ns/1ps
module sad_subtract_multiply_datapath
  import sad_mul_pkg::*;
(
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic issue_valid, // One-cycle issue strobe
  input wire logic [OP_W-1:0] issue_op, // Operation code, op_t
  input wire logic cond_pass, // Condition predicate evaluated true
  input wire logic set_flags, // Flag-update option on plain multiply
  input wire logic dest_present, // Destination named in the instruction
  input wire logic [REG_IDX_W-1:0] dest_reg, // Destination or low destination index
  input wire logic [REG_IDX_W-1:0] dest_hi_reg, // High destination for long forms
  input wire logic [REG_IDX_W-1:0] first_operand_reg, // First operand index
  input wire logic [REG_IDX_W-1:0] second_operand_reg, // Second operand index
  input wire logic [DATA_W-1:0] first_operand, // First operand value
  input wire logic [DATA_W-1:0] second_operand, // Second operand value
  input wire logic [DATA_W-1:0] addend, // Addend register value
  input wire logic [DATA_W-1:0] acc_lo, // Low destination current value
  input wire logic [DATA_W-1:0] acc_hi, // High destination current value
  input wire logic [3:0] flags_in, // Current N,Z,C,V
  output logic wr_en, // Write low or single result
  output logic [REG_IDX_W-1:0] wr_reg, // Index for wr_data
  output logic [DATA_W-1:0] wr_data, // Result or low word
  output logic wr_hi_en, // Write high word of long result
  output logic [REG_IDX_W-1:0] wr_hi_reg, // Index for wr_hi_data
  output logic [DATA_W-1:0] wr_hi_data, // High word of long result
  output logic flags_wr_en, // Flags updated this cycle
  output logic [3:0] flags_out, // New N,Z,C,V
  output logic issue_error // Restricted register use seen at issue
);

  logic [DATA_W-1:0] sad_total;
  logic [DATA_W-1:0] byte_lanes;
  logic [DATA_W-1:0] half_lanes;
  logic [WIDE_W-1:0] product;
  logic signed_mode;

  logic next_wr_en;
  logic [REG_IDX_W-1:0] next_wr_reg;
  logic [DATA_W-1:0] next_wr_data;
  logic next_wr_hi_en;
  logic [REG_IDX_W-1:0] next_wr_hi_reg;
  logic [DATA_W-1:0] next_wr_hi_data;
  logic next_flags_wr_en;
  logic [3:0] next_flags_out;
  logic next_issue_error;

  op_t op;
  logic [WIDE_W-1:0] wide_sum;
  logic [DATA_W-1:0] low_word;
  logic is_long;
  logic is_flag_mul;
  logic bad_reg;
  logic bad_flag_mul;

  assign op = op_t'(issue_op);
  assign signed_mode = (op == OP_SIGNED_WIDE_PRODUCT) || (op == OP_SIGNED_WIDE_PRODUCT_ACC);

  byte_abs_diff_unit u_sad (
    .first_operand(first_operand),
    .second_operand(second_operand),
    .total(sad_total),
    .byte_lanes(byte_lanes),
    .half_lanes(half_lanes)
  );

  wide_multiplier u_mul (
    .first_operand(first_operand),
    .second_operand(second_operand),
    .signed_mode(signed_mode),
    .product(product)
  );

  always_comb begin
    low_word = WORD_RESET;
    wide_sum = product;
    is_long = 1'b0;
    case (op)
      OP_BYTE_ABS_DIFF_TOTAL: begin
        low_word = sad_total;
      end
      OP_BYTE_ABS_DIFF_TOTAL_ACC: begin
        low_word = sad_total + addend;
      end
      OP_HALFWORD_LANE_DIFFERENCE: begin
        low_word = half_lanes;
      end
      OP_BYTE_LANE_DIFFERENCE: begin
        low_word = byte_lanes;
      end
      // Low word of the product is the same for either signedness
      OP_PRODUCT_LOW_WORD: begin
        low_word = product[DATA_W-1:0];
      end
      OP_PRODUCT_PLUS_ADDEND: begin
        low_word = product[DATA_W-1:0] + addend;
      end
      OP_ADDEND_MINUS_PRODUCT: begin
        low_word = addend - product[DATA_W-1:0];
      end
      OP_UNSIGNED_WIDE_PRODUCT, OP_SIGNED_WIDE_PRODUCT: begin
        is_long = 1'b1;
        wide_sum = product;
      end
      OP_UNSIGNED_WIDE_PRODUCT_ACC, OP_SIGNED_WIDE_PRODUCT_ACC: begin
        is_long = 1'b1;
        wide_sum = product + {acc_hi, acc_lo};
      end
      OP_UNSIGNED_WIDE_PRODUCT_TWO_ADDENDS: begin
        is_long = 1'b1;
        // Cannot overflow: (2^32-1)^2 + 2*(2^32-1) = 2^64-1
        wide_sum = product + {32'h0, acc_hi} + {32'h0, acc_lo};
      end
      default: begin
        low_word = WORD_RESET;
      end
    endcase
    if (is_long) begin
      low_word = wide_sum[DATA_W-1:0];
    end
  end

  // Bad register use is only reported; the result is still produced
  always_comb begin
    is_flag_mul = (op == OP_PRODUCT_LOW_WORD) && set_flags;
    bad_reg = (first_operand_reg == STACK_POINTER_REG)
      || (first_operand_reg == PROGRAM_COUNTER_REG)
      || (second_operand_reg == STACK_POINTER_REG)
      || (second_operand_reg == PROGRAM_COUNTER_REG)
      || (dest_present && ((dest_reg == STACK_POINTER_REG)
        || (dest_reg == PROGRAM_COUNTER_REG)))
      || (is_long && ((dest_hi_reg == STACK_POINTER_REG)
        || (dest_hi_reg == PROGRAM_COUNTER_REG)
        || (dest_hi_reg == dest_reg)));
    bad_flag_mul = is_flag_mul && ((first_operand_reg > LOW_REG_LIMIT)
      || (second_operand_reg > LOW_REG_LIMIT)
      || (dest_present && (dest_reg != second_operand_reg))
      || !cond_pass);
  end

  always_comb begin
    next_wr_en = 1'b0;
    next_wr_reg = wr_reg;
    next_wr_data = wr_data;
    next_wr_hi_en = 1'b0;
    next_wr_hi_reg = wr_hi_reg;
    next_wr_hi_data = wr_hi_data;
    next_flags_wr_en = 1'b0;
    next_flags_out = flags_out;
    next_issue_error = 1'b0;
    if (issue_valid) begin
      next_issue_error = bad_reg || bad_flag_mul;
      if (cond_pass) begin
        next_wr_en = 1'b1;
        next_wr_reg = dest_present ? dest_reg : first_operand_reg;
        next_wr_data = low_word;
        if (is_long) begin
          next_wr_reg = dest_reg;
          next_wr_hi_en = 1'b1;
          next_wr_hi_reg = dest_hi_reg;
          next_wr_hi_data = wide_sum[WIDE_W-1:DATA_W];
        end
        // Only the flag-setting multiply touches flags; all else keeps them
        if (is_flag_mul) begin
          next_flags_wr_en = 1'b1;
          next_flags_out = flags_in;
          next_flags_out[FLAG_N_BIT] = low_word[DATA_W-1];
          next_flags_out[FLAG_Z_BIT] = (low_word == WORD_RESET);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_en <= 1'b0;
      wr_reg <= '0;
      wr_data <= WORD_RESET;
      wr_hi_en <= 1'b0;
      wr_hi_reg <= '0;
      wr_hi_data <= WORD_RESET;
      flags_wr_en <= 1'b0;
      flags_out <= FLAGS_RESET;
      issue_error <= 1'b0;
    end else begin
      wr_en <= next_wr_en;
      wr_reg <= next_wr_reg;
      wr_data <= next_wr_data;
      wr_hi_en <= next_wr_hi_en;
      wr_hi_reg <= next_wr_hi_reg;
      wr_hi_data <= next_wr_hi_data;
      flags_wr_en <= next_flags_wr_en;
      flags_out <= next_flags_out;
      issue_error <= next_issue_error;
    end
  end

endmodule : sad_subtract_multiply_datapath

//--- hw/wide_multiplier.sv
`timescale 1ns/1ps
module wide_multiplier
  import sad_mul_pkg::*;
(
  input wire logic [DATA_W-1:0] first_operand, // Multiplicand
  input wire logic [DATA_W-1:0] second_operand, // Multiplier
  input wire logic signed_mode, // Treat operands as two's complement
  output logic [WIDE_W-1:0] product // Full 64-bit product
);

  logic [WIDE_W:0] a_ext;
  logic [WIDE_W:0] b_ext;
  logic [2*WIDE_W+1:0] full;

  // Sign or zero extension picks the interpretation; one array serves both
  assign a_ext = {{(WIDE_W-DATA_W+1){signed_mode & first_operand[DATA_W-1]}}, first_operand};
  assign b_ext = {{(WIDE_W-DATA_W+1){signed_mode & second_operand[DATA_W-1]}}, second_operand};
  assign full = a_ext * b_ext;
  assign product = full[WIDE_W-1:0];

endmodule : wide_multiplier

//--- tb/core_reg_file.sv
`timescale 1ns/1ps
module core_reg_file
  import sad_mul_pkg::*;
(
  input wire logic ref_clk, // Core clock
  input wire logic wr_en, wr_hi_en, // Write strobes
  input wire logic [REG_IDX_W-1:0] wr_reg, wr_hi_reg, // Write indices
  input wire logic [DATA_W-1:0] wr_data, wr_hi_data // Write values
);
  // Results land here so the bench sees which register really took them
  logic [DATA_W-1:0] regs [16];
  always_ff @(posedge ref_clk) begin
    if (wr_en) regs[wr_reg] <= wr_data;
    if (wr_hi_en) regs[wr_hi_reg] <= wr_hi_data;
  end
endmodule : core_reg_file

//--- tb/sad_mul_chk.sv
`timescale 1ns/1ps
module sad_mul_chk
  import sad_mul_pkg::*;
(
  input wire logic ref_clk, rst, issue_valid, cond_pass, set_flags, dest_present, // Controls
  input wire logic [OP_W-1:0] issue_op, // Op code
  input wire logic [REG_IDX_W-1:0] first_operand_reg, wr_reg, // Indices
  input wire logic [DATA_W-1:0] first_operand, second_operand, addend, // Operands
  input wire logic [DATA_W-1:0] wr_data, wr_hi_data, // Results
  input wire logic [3:0] flags_in, flags_out, // Flags
  input wire logic wr_en, wr_hi_en, flags_wr_en // Strobes
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic go;
  logic [WIDE_W-1:0] p_q;
  logic [DATA_W-1:0] a_q;
  logic [3:0] f_q;
  assign go = issue_valid && cond_pass;
  // Full product kept so one copy serves the 32-bit and 64-bit checks
  always_ff @(posedge ref_clk) begin
    p_q <= 64'(first_operand) * 64'(second_operand);
    a_q <= addend;
    f_q <= flags_in;
  end
  quiet_false_a: assert property (
    issue_valid && !cond_pass |=> !(wr_en || wr_hi_en || flags_wr_en)) else $error("late write");
  mul_low_a: assert property (
    go && issue_op == 4'h4 |=> wr_en && wr_data == p_q[31:0]) else $error("bad product");
  mac_add_a: assert property (
    go && issue_op == 4'h5 |=> wr_data == p_q[31:0] + a_q) else $error("bad mac");
  mac_sub_a: assert property (
    go && issue_op == 4'h6 |=> wr_data == a_q - p_q[31:0]) else $error("bad msub");
  nz_flags_a: assert property (go && issue_op == 4'h4 && set_flags |=>
    flags_wr_en && flags_out == {wr_data[31], wr_data == 32'h0, f_q[1:0]}) else $error("flags");
  flags_kept_a: assert property (
    issue_valid && !(issue_op == 4'h4 && set_flags) |=> !flags_wr_en) else $error("flag write");
  dest_fb_a: assert property (go && !dest_present && issue_op < 4'h7 |=>
    wr_reg == $past(first_operand_reg)) else $error("bad fallback");
  wide_a: assert property (
    go && issue_op == 4'h7 |=> wr_hi_en && {wr_hi_data, wr_data} == p_q) else $error("bad wide");
  cover property (go && issue_op == 4'h7);
  cover property (go && issue_op == 4'h4 && set_flags);
  cover property (issue_valid && !cond_pass);
endmodule : sad_mul_chk
bind sad_subtract_multiply_datapath sad_mul_chk chk_u (.ref_clk, .rst, .issue_valid, .cond_pass,
  .set_flags, .dest_present, .issue_op, .first_operand_reg, .wr_reg, .first_operand,
  .second_operand, .addend, .wr_data, .wr_hi_data, .flags_in, .flags_out, .wr_en, .wr_hi_en,
  .flags_wr_en);

//--- tb/sad_subtract_multiply_datapath_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module sad_subtract_multiply_datapath_tb
  import sad_mul_pkg::*;
;
  logic ref_clk = 1'b0, rst = 1'b1, issue_valid = 1'b0, cond_pass = 1'b1;
  logic set_flags = 1'b0, dest_present = 1'b1, wr_en, wr_hi_en, flags_wr_en, issue_error;
  logic [3:0] issue_op = 4'h0, dest_hi_reg = 4'h6, flags_in = 4'h3, dest_reg = 4'h1;
  logic [3:0] first_operand_reg = 4'h3, second_operand_reg = 4'h4, wr_reg, wr_hi_reg, flags_out;
  logic [31:0] first_operand = 32'h0, second_operand = 32'h0, addend = 32'h0;
  logic [31:0] acc_lo = 32'h0, acc_hi = 32'h0, wr_data, wr_hi_data;
  int n_tests = 0;
  int n_errors = 0;
  always #4 ref_clk = ~ref_clk;
  sad_subtract_multiply_datapath dut_u (.ref_clk, .rst, .issue_valid, .issue_op, .cond_pass,
    .set_flags, .dest_present, .dest_reg, .dest_hi_reg, .first_operand_reg, .second_operand_reg,
    .first_operand, .second_operand, .addend, .acc_lo, .acc_hi, .flags_in, .wr_en, .wr_reg,
    .wr_data, .wr_hi_en, .wr_hi_reg, .wr_hi_data, .flags_wr_en, .flags_out, .issue_error);
  core_reg_file rf_u (.ref_clk, .wr_en, .wr_hi_en, .wr_reg, .wr_hi_reg, .wr_data, .wr_hi_data);
  task automatic ctl(input logic cp, sf, dp, input logic [3:0] d, rn, rm);
    @(posedge ref_clk);
    {cond_pass, set_flags, dest_present, dest_reg, first_operand_reg, second_operand_reg}
      <= {cp, sf, dp, d, rn, rm};
  endtask : ctl
  task automatic go(input logic [3:0] op, input logic [31:0] a, b, c = 32'h0, lo = 32'h0,
    hi = 32'h0);
    @(posedge ref_clk);
    {issue_op, first_operand, second_operand, addend, acc_lo, acc_hi, issue_valid}
      <= {op, a, b, c, lo, hi, 1'b1};
    @(posedge ref_clk);
    issue_valid <= 1'b0;
    #1;
  endtask : go
  task automatic t_diff;
    ctl(1'b1, 1'b1, 1'b1, 4'h1, 4'h3, 4'h4);
    go(4'h0, 32'h01FF8010, 32'hFF017F20);
    `CHK("sad", 32'h0000020D, wr_data)
    `CHK("sad flags", 1'b0, flags_wr_en)
    go(4'h1, 32'h01FF8010, 32'hFF017F20, 32'hFFFFFFFF);
    `CHK("sad acc", 32'h0000020C, wr_data)
    go(4'h2, 32'h00018000, 32'h00020001);
    `CHK("half", 32'hFFFF7FFF, wr_data)
    go(4'h3, 32'h00018000, 32'h00020001);
    `CHK("byte", 32'h00FF80FF, wr_data)
    `CHK("lane flags", 1'b0, flags_wr_en)
    $display("difference test end");
  endtask : t_diff
  task automatic t_mul;
    ctl(1'b1, 1'b0, 1'b0, 4'h1, 4'h5, 4'h4);
    go(4'h4, 32'hFFFFFFFE, 32'h3);
    `CHK("mul", 32'hFFFFFFFA, wr_data)
    `CHK("mul reg", 4'h5, wr_reg)
    `CHK("mul no flags", 1'b0, flags_wr_en)
    go(4'h5, 32'hFFFFFFFE, 32'h3, 32'h10);
    `CHK("mul kept", 32'hFFFFFFFA, rf_u.regs[5])
    `CHK("mla", 32'h0000000A, wr_data)
    go(4'h6, 32'hFFFFFFFE, 32'h3, 32'h10);
    `CHK("mls", 32'h00000016, wr_data)
    $display("multiply test end");
  endtask : t_mul
  task automatic t_flags;
    ctl(1'b1, 1'b1, 1'b1, 4'h2, 4'h3, 4'h2);
    go(4'h4, 32'h0, 32'h5);
    `CHK("zero flags", 5'h17, {flags_wr_en, flags_out})
    go(4'h4, 32'hFFFFFFFF, 32'h1);
    `CHK("neg flags", 5'h1B, {flags_wr_en, flags_out})
    `CHK("legal", 1'b0, issue_error)
    ctl(1'b0, 1'b1, 1'b1, 4'h2, 4'h3, 4'h2);
    go(4'h4, 32'h2, 32'h3);
    `CHK("false pred", 2'b00, {wr_en, flags_wr_en})
    $display("flag test end");
  endtask : t_flags
  task automatic t_wide;
    logic [31:0] lo [5] = '{32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF};
    logic [31:0] hi [5] = '{32'h0, 32'h0, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF};
    logic [63:0] ex [5] = '{64'hFFFFFFFE00000001, 64'hFFFFFFFF00000000, '1, 64'h1, 64'h0};
    ctl(1'b1, 1'b0, 1'b1, 4'h1, 4'h3, 4'h4);
    for (int i = 0; i < 5; i++) begin
      go(4'(7 + i), 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, lo[i], hi[i]);
      `CHK("wide", {1'b1, ex[i]}, {wr_hi_en, wr_hi_data, wr_data})
      `CHK("wide regs", 8'h61, {wr_hi_reg, wr_reg})
    end
    $display("wide test end");
  endtask : t_wide
  task automatic t_err;
    ctl(1'b1, 1'b0, 1'b1, 4'h1, STACK_POINTER_REG, 4'h4);
    go(4'h0, 32'h1, 32'h2);
    `CHK("sp operand", 1'b1, issue_error)
    ctl(1'b1, 1'b1, 1'b1, 4'h1, 4'h3, 4'h4);
    go(4'h4, 32'h1, 32'h2);
    `CHK("flag dest", 1'b1, issue_error)
    $display("error test end");
  endtask : t_err
  task automatic give_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_diff;
    t_mul;
    t_flags;
    t_wide;
    t_err;
    give_verdict;
  end
  // Whole run is well under a hundred cycles
  initial begin
    #5000;
    n_errors++;
    give_verdict;
  end
endmodule : sad_subtract_multiply_datapath_tb
